// ### hw/audio_ctl_pkg.sv
/*
  Constants for the audio path control and status register bank.
  Assumes an 8-bit register port with byte offsets as listed.
*/
package audio_ctl_pkg;

  // ---------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SIDETONE_PATH_CONTROL    = 8'h3A;
  localparam logic [7:0] ADDR_SIDETONE_GAIN_LEVEL      = 8'h3B;
  localparam logic [7:0] ADDR_LEFT_OUTPUT_SOURCE_MASK  = 8'h3C;
  localparam logic [7:0] ADDR_RIGHT_OUTPUT_SOURCE_MASK = 8'h3D;
  localparam logic [7:0] ADDR_INPUT_SIDE_MODE_SELECT   = 8'h50;
  localparam logic [7:0] ADDR_OUTPUT_SIDE_MODE_SELECT  = 8'h51;
  localparam logic [7:0] ADDR_DAC_STREAM_POLARITY      = 8'h99;
  localparam logic [7:0] ADDR_CONTROLLER_BUSY_STATUS   = 8'hE0;
  localparam logic [7:0] ADDR_IRQ_STATUS               = 8'hF0;
  localparam logic [7:0] ADDR_IRQ_MASK                 = 8'hF1;
  localparam logic [7:0] ADDR_STANDBY_RUN_SELECT       = 8'hFD;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int POL_RIGHT_BIT    = 7;
  localparam int POL_LEFT_BIT     = 3;
  localparam int ST_ENABLE_BIT    = 7;
  localparam int ST_MUTE_BIT      = 6;
  localparam int SUBMIT_BIT       = 0;
  localparam int RUN_BIT          = 0;
  localparam int GEN_BUSY_BIT     = 0;
  localparam int MODE_BUSY_BIT    = 1;
  localparam int MIC_MODE_BIT         = 2;
  localparam int INPUT_MIXER_MODE_BIT = 4;
  localparam int ADC_MODE_BIT         = 6;

  // ---------------------------------------------------------------
  // Reset values and field constants.
  // ---------------------------------------------------------------
  localparam logic [3:0] GAIN_RESET     = 4'hE;
  localparam logic [3:0] GAIN_RESERVED  = 4'hF;
  localparam logic [2:0] LEFT_MASK_RST  = 3'h1;
  localparam logic [2:0] RIGHT_MASK_RST = 3'h2;
  localparam logic [6:0] IN_MODE_VALID  = 7'h2A;  // Bits 2, 4, 6 of the register.
  localparam logic [6:0] OUT_MODE_VALID = 7'h78;  // Bits 4 to 7 of the register.

  // ---------------------------------------------------------------
  // Controller sequencing times.
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ      = 250;
  localparam int MODE_SEQ_NS      = 64;
  localparam int GEN_SEQ_NS       = 128;
  localparam int MODE_SEQ_CYCLES  = (MODE_SEQ_NS * REF_CLK_MHZ) / 1000;
  localparam int GEN_SEQ_CYCLES   = (GEN_SEQ_NS * REF_CLK_MHZ) / 1000;

  // Interrupt status bit positions.
  localparam int IRQ_MODE_DONE_BIT = 0;
  localparam int IRQ_GEN_DONE_BIT  = 1;
  localparam int IRQ_BAD_GAIN_BIT  = 2;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_MODE,
    SEQ_GEN
  } seq_state_t;

endpackage

// ### hw/audio_ctl_regs.sv
/*
  Audio path control and status register bank with DAC polarity,
  sidetone control, output source masks and the mode controllers.
  Assumes a same-clock register master and 24-bit signed sample inputs
  that are already synchronous to ref_clk.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Right polarity bit 7 set negates every right DAC sample; resets clear.
// - Left polarity bit 3 set negates every left DAC sample; resets clear.
// - Sidetone control bit 7 enables the sidetone path; resets off.
// - Sidetone control bit 6 mutes sidetone output; resets muted.
// - Gain 0 is -42 dB, 3 dB steps to 0 dB at 14; 15 reserved.
// - Left output mask: bit0 filter left, bit1 filter right, bit2 sidetone; reset 1.
// - Right output mask has same meanings; resets to 2.
// - Run select bit 0: zero standby, one active; resets standby.
// - Input mode bits 7:1: mic at 2, mixer at 4, ADC at 6; reset 0.
// - Output mode bits 7:1: headphones at 4,5, DACs at 6,7; reset 0.
// - Submit bit in input mode register applies both mode selections together when both controllers are idle.
// - Status bit 1 reads one while the mode controller works.
// - Status bit 0 reads one while the general controller works.
module audio_ctl_regs
  import audio_ctl_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [7:0]         reg_rdata,
  input  wire logic signed [23:0] dac_left_in,
  input  wire logic signed [23:0] dac_right_in,
  input  wire logic signed [23:0] filt_left_in,
  input  wire logic signed [23:0] filt_right_in,
  input  wire logic signed [23:0] sidetone_in,
  output logic signed [23:0]      dac_left_out,
  output logic signed [23:0]      dac_right_out,
  output logic signed [23:0]      out_left,
  output logic signed [23:0]      out_right,
  output logic [6:0]              active_input_mode,
  output logic [6:0]              active_output_mode,
  output logic                    system_active,
  output logic                    irq
);

  // ---------------------------------------------------------------
  // Register storage.
  // ---------------------------------------------------------------
  logic              right_invert;
  logic              left_invert;
  logic              sidetone_enable;
  logic              sidetone_mute;
  logic [3:0]        sidetone_gain;
  logic [2:0]        left_output_source_mask;
  logic [2:0]        right_output_source_mask;
  logic [6:0]        input_mode_pending;
  logic [6:0]        output_mode_pending;
  logic              run_select;
  logic [2:0]        irq_status;
  logic [2:0]        irq_mask;
  logic [2:0]        irq_event;
  logic [2:0]        next_irq_status;
  logic              mode_controller_busy;
  logic              general_controller_busy;
  seq_state_t        seq_state;
  logic [7:0]        seq_count;
  logic signed [23:0] sidetone_scaled;

  // Write decode helper shared by every register.
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = clk_en && reg_write && (reg_addr == a);
  endfunction

  // Gain in 3 dB steps: a halving per 6 dB, with 3 dB odd steps taken as
  // multiplication by 0.75 (about -2.5 dB) as a low-cost approximation.
  function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
                                                   input logic [3:0] g);
    logic [3:0]         atten;
    logic signed [23:0] half;
    atten = 4'hE - g;
    half  = s >>> atten[3:1];
    if (atten[0]) begin
      apply_gain = half - (half >>> 2);
    end else begin
      apply_gain = half;
    end
  endfunction

  // Sum of mask-enabled sources.
  function automatic logic signed [23:0] mix(input logic [2:0] m,
                                            input logic signed [23:0] sl,
                                            input logic signed [23:0] sr,
                                            input logic signed [23:0] st);
    mix = (m[0] ? sl : 24'sh0) + (m[1] ? sr : 24'sh0) + (m[2] ? st : 24'sh0);
  endfunction

  // ---------------------------------------------------------------
  // Control registers.
  // ---------------------------------------------------------------
  // Polarity register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      right_invert <= 1'b0;
      left_invert  <= 1'b0;
    end else if (wr_hit(ADDR_DAC_STREAM_POLARITY)) begin
      right_invert <= reg_wdata[POL_RIGHT_BIT];
      left_invert  <= reg_wdata[POL_LEFT_BIT];
    end
  end

  // Sidetone control and gain; a reserved gain code is refused.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sidetone_enable <= 1'b0;
      sidetone_mute   <= 1'b1;
      sidetone_gain   <= GAIN_RESET;
    end else begin
      if (wr_hit(ADDR_SIDETONE_PATH_CONTROL)) begin
        sidetone_enable <= reg_wdata[ST_ENABLE_BIT];
        sidetone_mute   <= reg_wdata[ST_MUTE_BIT];
      end
      if (wr_hit(ADDR_SIDETONE_GAIN_LEVEL) && reg_wdata[3:0] != GAIN_RESERVED) begin
        sidetone_gain <= reg_wdata[3:0];
      end
    end
  end

  // Output source masks.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      left_output_source_mask  <= LEFT_MASK_RST;
      right_output_source_mask <= RIGHT_MASK_RST;
    end else begin
      if (wr_hit(ADDR_LEFT_OUTPUT_SOURCE_MASK)) begin
        left_output_source_mask <= reg_wdata[2:0];
      end
      if (wr_hit(ADDR_RIGHT_OUTPUT_SOURCE_MASK)) begin
        right_output_source_mask <= reg_wdata[2:0];
      end
    end
  end

  // Pending mode selections and run select; output bit 0 is not stored.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      input_mode_pending  <= 7'h00;
      output_mode_pending <= 7'h00;
      run_select          <= 1'b0;
    end else begin
      if (wr_hit(ADDR_INPUT_SIDE_MODE_SELECT)) begin
        input_mode_pending <= reg_wdata[7:1] & IN_MODE_VALID;
      end
      if (wr_hit(ADDR_OUTPUT_SIDE_MODE_SELECT)) begin
        output_mode_pending <= reg_wdata[7:1] & OUT_MODE_VALID;
      end
      if (wr_hit(ADDR_STANDBY_RUN_SELECT)) begin
        run_select <= reg_wdata[RUN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode and general controllers.
  // ---------------------------------------------------------------
  // A submit while idle latches both selections at once, then the mode controller
  // runs its sequence and hands over to the general controller.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_state               <= SEQ_IDLE;
      seq_count               <= 8'h00;
      active_input_mode       <= 7'h00;
      active_output_mode      <= 7'h00;
      mode_controller_busy    <= 1'b0;
      general_controller_busy <= 1'b0;
    end else if (clk_en) begin
      case (seq_state)
        SEQ_IDLE: begin
          if (wr_hit(ADDR_INPUT_SIDE_MODE_SELECT) && reg_wdata[SUBMIT_BIT]) begin
            active_input_mode    <= reg_wdata[7:1] & IN_MODE_VALID;
            active_output_mode   <= output_mode_pending;
            mode_controller_busy <= 1'b1;
            general_controller_busy <= 1'b1;
            seq_count            <= 8'(MODE_SEQ_CYCLES - 1);
            seq_state            <= SEQ_MODE;
          end else if (wr_hit(ADDR_STANDBY_RUN_SELECT)) begin
            general_controller_busy <= 1'b1;
            seq_count            <= 8'(GEN_SEQ_CYCLES - 1);
            seq_state            <= SEQ_GEN;
          end
        end
        SEQ_MODE: begin
          if (seq_count == 8'h00) begin
            mode_controller_busy <= 1'b0;
            seq_count            <= 8'(GEN_SEQ_CYCLES - 1);
            seq_state            <= SEQ_GEN;
          end else begin
            seq_count <= seq_count - 8'h01;
          end
        end
        SEQ_GEN: begin
          if (seq_count == 8'h00) begin
            general_controller_busy <= 1'b0;
            seq_state               <= SEQ_IDLE;
          end else begin
            seq_count <= seq_count - 8'h01;
          end
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupts.
  // ---------------------------------------------------------------
  // Sticky events: mode done, general done, reserved gain write.
  // A new event wins over a write-one-to-clear in the same cycle.
  always_comb begin
    irq_event                    = 3'h0;
    irq_event[IRQ_MODE_DONE_BIT] = (seq_state == SEQ_MODE) && (seq_count == 8'h00);
    irq_event[IRQ_GEN_DONE_BIT]  = (seq_state == SEQ_GEN) && (seq_count == 8'h00);
    irq_event[IRQ_BAD_GAIN_BIT]  = wr_hit(ADDR_SIDETONE_GAIN_LEVEL)
                                   && (reg_wdata[3:0] == GAIN_RESERVED);
    next_irq_status = irq_status;
    if (wr_hit(ADDR_IRQ_STATUS)) begin
      next_irq_status = next_irq_status & ~reg_wdata[2:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  // Status, mask and the registered interrupt level.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_status <= 3'h0;
      irq_mask   <= 3'h0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
      if (wr_hit(ADDR_IRQ_MASK)) begin
        irq_mask <= reg_wdata[2:0];
        irq      <= |(next_irq_status & reg_wdata[2:0]);
      end else begin
        irq      <= |(next_irq_status & irq_mask);
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port.
  // ---------------------------------------------------------------
  // Read data stand in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        case (reg_addr)
          ADDR_DAC_STREAM_POLARITY:
            reg_rdata <= {right_invert, 3'h0, left_invert, 3'h0};
          ADDR_SIDETONE_PATH_CONTROL:
            reg_rdata <= {sidetone_enable, sidetone_mute, 6'h00};
          ADDR_SIDETONE_GAIN_LEVEL:      reg_rdata <= {4'h0, sidetone_gain};
          ADDR_LEFT_OUTPUT_SOURCE_MASK:  reg_rdata <= {5'h00, left_output_source_mask};
          ADDR_RIGHT_OUTPUT_SOURCE_MASK: reg_rdata <= {5'h00, right_output_source_mask};
          ADDR_INPUT_SIDE_MODE_SELECT:   reg_rdata <= {input_mode_pending, 1'b0};
          ADDR_OUTPUT_SIDE_MODE_SELECT:  reg_rdata <= {output_mode_pending, 1'b0};
          ADDR_CONTROLLER_BUSY_STATUS:
            reg_rdata <= {6'h00, mode_controller_busy, general_controller_busy};
          ADDR_STANDBY_RUN_SELECT:       reg_rdata <= {7'h00, run_select};
          ADDR_IRQ_STATUS:               reg_rdata <= {5'h00, irq_status};
          ADDR_IRQ_MASK:                 reg_rdata <= {5'h00, irq_mask};
          default:                       reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Sample path.
  // ---------------------------------------------------------------
  // Sidetone is zero when disabled or muted, else scaled by the gain.
  always_comb begin
    if (sidetone_enable && !sidetone_mute) begin
      sidetone_scaled = apply_gain(sidetone_in, sidetone_gain);
    end else begin
      sidetone_scaled = 24'sh0;
    end
  end

  // Registered audio outputs; standby holds the run output low.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dac_left_out  <= 24'sh0;
      dac_right_out <= 24'sh0;
      out_left      <= 24'sh0;
      out_right     <= 24'sh0;
      system_active <= 1'b0;
    end else if (clk_en) begin
      dac_left_out  <= left_invert ? -dac_left_in : dac_left_in;
      dac_right_out <= right_invert ? -dac_right_in : dac_right_in;
      out_left  <= mix(left_output_source_mask, filt_left_in, filt_right_in,
                       sidetone_scaled);
      out_right <= mix(right_output_source_mask, filt_left_in, filt_right_in,
                       sidetone_scaled);
      system_active <= run_select;
    end
  end

endmodule

`default_nettype wire

// ### verification/audio_ctl_props.sv
/*
  Port checker for the audio path control register bank.
  Assumes one clock, ref_clk, and a synchronous active-high sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none
module audio_ctl_props
  import audio_ctl_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_write,
  input wire logic               reg_read,
  input wire logic [7:0]         reg_rdata,
  input wire logic signed [23:0] dac_left_in,
  input wire logic signed [23:0] dac_right_in,
  input wire logic signed [23:0] dac_left_out,
  input wire logic signed [23:0] dac_right_out,
  input wire logic signed [23:0] out_right,
  input wire logic [6:0]         active_input_mode,
  input wire logic [6:0]         active_output_mode,
  input wire logic               system_active,
  input wire logic               irq
);
  // ---------------------------------------------------------------
  // Helper logic.
  // ---------------------------------------------------------------
  logic       wr_on;
  logic [5:0] quiet;
  logic       run_bit;
  assign wr_on = clk_en && reg_write;

  // Counts cycles since a sequence could last have started.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (wr_on && (reg_addr == ADDR_STANDBY_RUN_SELECT ||
        (reg_addr == ADDR_INPUT_SIDE_MODE_SELECT && reg_wdata[SUBMIT_BIT])))) begin
      quiet <= 6'h00;
    end else if (quiet != 6'h3F) begin
      quiet <= quiet + 6'h01;
    end
  end

  // Keeps the last run-select bit written.
  always_ff @(posedge ref_clk) begin
    if (wr_on && reg_addr == ADDR_STANDBY_RUN_SELECT) begin
      run_bit <= reg_wdata[RUN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_read_idle: assert property (clk_en && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_right_invert: assert property (wr_on && reg_addr == ADDR_DAC_STREAM_POLARITY
    && reg_wdata[POL_RIGHT_BIT] ##1 clk_en |=> dac_right_out == -$past(dac_right_in))
    else $error("right stream not negated");
  a_left_pass: assert property (wr_on && reg_addr == ADDR_DAC_STREAM_POLARITY
    && !reg_wdata[POL_LEFT_BIT] ##1 clk_en |=> dac_left_out == $past(dac_left_in))
    else $error("left stream altered");
  a_gain_refuse: assert property (wr_on && reg_addr == ADDR_SIDETONE_GAIN_LEVEL
    && reg_wdata[3:0] == GAIN_RESERVED ##[1:2] clk_en && reg_read
    && reg_addr == ADDR_SIDETONE_GAIN_LEVEL |=> reg_rdata[3:0] != GAIN_RESERVED)
    else $error("reserved gain code stored");
  a_mode_hold: assert property (wr_on && reg_addr == ADDR_INPUT_SIDE_MODE_SELECT
    && !reg_wdata[SUBMIT_BIT] && quiet == 6'h3F
    |=> $stable(active_input_mode) && $stable(active_output_mode))
    else $error("modes changed without submit");
  a_run_follow: assert property (wr_on && reg_addr == ADDR_STANDBY_RUN_SELECT
    |-> ##[1:2] system_active == run_bit)
    else $error("run state does not follow its bit");
  a_busy_submit: assert property (wr_on && reg_addr == ADDR_INPUT_SIDE_MODE_SELECT
    && reg_wdata[SUBMIT_BIT] && quiet == 6'h3F ##[1:2] clk_en && reg_read
    && reg_addr == ADDR_CONTROLLER_BUSY_STATUS |=> reg_rdata[1:0] == 2'b11)
    else $error("busy flags not set after submit");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !system_active
    && active_input_mode == 7'h00 && active_output_mode == 7'h00)
    else $error("outputs not cleared by reset");
  a_outputs_frozen: assert property (!clk_en |=> $stable(dac_left_out) && $stable(out_right))
    else $error("outputs moved while disabled");

  c_submit: cover property (wr_on && reg_addr == ADDR_INPUT_SIDE_MODE_SELECT && reg_wdata[0]);
  c_invert: cover property (wr_on && reg_addr == ADDR_DAC_STREAM_POLARITY && reg_wdata[7]);
  c_gain_irq: cover property (wr_on && reg_wdata == 8'h0F ##[1:3] irq);
endmodule

bind audio_ctl_regs audio_ctl_props audio_ctl_props_i (.*);
`default_nettype wire

// ### verification/tb_audio_ctl_regs.sv
/*
  Self-checking bench for the audio path control register bank.
  Assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_audio_ctl_regs;
  import audio_ctl_pkg::*;
  logic               ref_clk, sys_rst, clk_en, reg_write, reg_read, irq, system_active;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata, rv;
  logic signed [23:0] dac_left_in, dac_right_in, filt_left_in, filt_right_in, sidetone_in;
  logic signed [23:0] dac_left_out, dac_right_out, out_left, out_right;
  logic signed [23:0] e_dl, e_dr, e_ol, e_or;
  logic [6:0]         active_input_mode, active_output_mode;
  logic [7:0]         m_pol, m_ctl, m_lm, m_rm;
  logic [3:0]         m_gain;
  int                 n_mismatch, n_checks, seed;
  bit                 live;
  logic [7:0] ra [11] = '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h50, 8'h51, 8'h99, 8'hE0, 8'hFD,
                          8'hF0, 8'hF1};
  logic [7:0] re [11] = '{8'h40, 8'h0E, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00};
  logic [7:0] pv [4] = '{8'h80, 8'h08, 8'h00, 8'h88};
  logic [7:0] cv [3] = '{8'h80, 8'hC0, 8'h00};

  audio_ctl_regs audio_ctl_regs_i (.*);

  // ---------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    case (a)
      ADDR_DAC_STREAM_POLARITY: m_pol = d;
      ADDR_SIDETONE_PATH_CONTROL: m_ctl = d;
      ADDR_LEFT_OUTPUT_SOURCE_MASK: m_lm = d;
      ADDR_RIGHT_OUTPUT_SOURCE_MASK: m_rm = d;
      ADDR_SIDETONE_GAIN_LEVEL: if (d[3:0] != GAIN_RESERVED) m_gain = d[3:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk("reg_rdata", e, rv);
  endtask

  // Polls the busy flags under a bound.
  task automatic wait_idle;
    for (int k = 0; k < 40; k++) begin
      rd(ADDR_CONTROLLER_BUSY_STATUS);
      if (rv[1:0] === 2'b00) return;
    end
    chk("busy", 0, rv);
  endtask

  task automatic do_reset;
    sys_rst <= 1'b1;
    m_pol = 8'h00;
    m_ctl = 8'h40;
    m_lm = 8'h01;
    m_rm = 8'h02;
    m_gain = 4'hE;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sidetone loses one halving per 6 dB below code 14; an odd 3 dB step is x0.75.
  function automatic logic [23:0] mix(input logic [7:0] m);
    logic [23:0]        s;
    logic signed [23:0] t;
    s = 24'h000000;
    t = sidetone_in >>> ((14 - m_gain) / 2);
    if ((14 - m_gain) % 2 == 1) t = t - (t >>> 2);
    if (m[0]) s = s + filt_left_in;
    if (m[1]) s = s + filt_right_in;
    if (m[2] && m_ctl[7] && !m_ctl[6]) s = s + t;
    return s;
  endfunction

  // ---------------------------------------------------------------
  // Clock, samples, per-cycle model and watchdog.
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Fresh random samples every cycle.
  always @(posedge ref_clk) begin
    dac_left_in <= 24'($random(seed));
    dac_right_in <= 24'($random(seed));
    filt_left_in <= 24'($random(seed));
    filt_right_in <= 24'($random(seed));
    sidetone_in <= 24'($random(seed));
  end

  // Compares outputs, then predicts the next edge; a disabled edge keeps them.
  always @(negedge ref_clk) begin
    if (live) begin
      chk("dac_left_out", e_dl, dac_left_out);
      chk("dac_right_out", e_dr, dac_right_out);
      chk("out_left", e_ol, out_left);
      chk("out_right", e_or, out_right);
    end
    if (clk_en) begin
      e_dl = m_pol[3] ? -dac_left_in : dac_left_in;
      e_dr = m_pol[7] ? -dac_right_in : dac_right_in;
      e_ol = mix(m_lm);
      e_or = mix(m_rm);
    end
    live = !sys_rst;
  end

  initial begin
    #(20000 * 4);
    n_mismatch++;
    print_verdict;
  end

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hC94967AD;
    {clk_en, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {dac_left_in, dac_right_in, filt_left_in, filt_right_in, sidetone_in} = '0;
    clk_en = 1'b1;
    do_reset;
    foreach (ra[i]) rc(ra[i], re[i]);
    rc(8'h00, 8'h00);
    foreach (pv[i]) begin
      wr(ADDR_DAC_STREAM_POLARITY, pv[i]);
      repeat (6) @(posedge ref_clk);
    end
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_LEFT_OUTPUT_SOURCE_MASK, 8'(m));
      wr(ADDR_RIGHT_OUTPUT_SOURCE_MASK, 8'(7 - m));
      wr(ADDR_SIDETONE_PATH_CONTROL, cv[m % 3]);
      wr(ADDR_SIDETONE_GAIN_LEVEL, 8'(m + 7));
      repeat (4) @(posedge ref_clk);
    end
    rc(ADDR_LEFT_OUTPUT_SOURCE_MASK, 8'h07);
    wr(ADDR_SIDETONE_PATH_CONTROL, 8'h40);
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_SIDETONE_GAIN_LEVEL, 8'h0F);
    rc(ADDR_SIDETONE_GAIN_LEVEL, 8'h0E);
    chk("irq", 1, irq);
    wr(ADDR_IRQ_MASK, 8'h03);
    rc(ADDR_IRQ_STATUS, 8'h04);
    chk("irq", 0, irq);
    wr(ADDR_IRQ_STATUS, 8'h04);
    wr(ADDR_IRQ_MASK, 8'h07);
    rc(ADDR_IRQ_STATUS, 8'h00);
    chk("irq", 0, irq);
    wr(ADDR_SIDETONE_GAIN_LEVEL, 8'h05);
    rc(ADDR_SIDETONE_GAIN_LEVEL, 8'h05);
    wr(ADDR_SIDETONE_GAIN_LEVEL, 8'h0E);
    wr(ADDR_OUTPUT_SIDE_MODE_SELECT, 8'hFF);
    rc(ADDR_OUTPUT_SIDE_MODE_SELECT, 8'hF0);
    wr(ADDR_INPUT_SIDE_MODE_SELECT, 8'hFE);
    rc(ADDR_INPUT_SIDE_MODE_SELECT, 8'h54);
    rc(ADDR_CONTROLLER_BUSY_STATUS, 8'h00);
    chk("active_output_mode", 0, active_output_mode);
    wr(ADDR_INPUT_SIDE_MODE_SELECT, 8'hFF);
    rc(ADDR_CONTROLLER_BUSY_STATUS, 8'h03);
    wr(ADDR_INPUT_SIDE_MODE_SELECT, 8'h05);
    wait_idle;
    chk("active_input_mode", 7'h2A, active_input_mode);
    chk("active_output_mode", 7'h78, active_output_mode);
    rc(ADDR_INPUT_SIDE_MODE_SELECT, 8'h04);
    rc(ADDR_IRQ_STATUS, 8'h03);
    chk("irq", 1, irq);
    wr(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_STANDBY_RUN_SELECT, 8'h01);
    rc(ADDR_CONTROLLER_BUSY_STATUS, 8'h01);
    chk("system_active", 1, system_active);
    wait_idle;
    repeat (40) begin
      @(posedge ref_clk);
      clk_en <= 1'($random(seed));
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    do_reset;
    rc(ADDR_STANDBY_RUN_SELECT, 8'h00);
    chk("active_input_mode", 0, active_input_mode);
    repeat (4) @(posedge ref_clk);
    print_verdict;
  end
endmodule
`default_nettype wire
